// ### jtl_pkg.sv
// Shared constants, types and code tables for the transmit link layer.
package jtl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;

  typedef enum logic [1:0] {
    ST_CGS = 2'b00,
    ST_ILA = 2'b01,
    ST_DATA = 2'b10
  } jtl_state_e;

  typedef struct packed {
    logic tp_constant;
    logic [2:0] link_test_select;
    logic reset_mask_after_first;
    logic reset_mask_phase_dividers;
    logic reset_mask_dividers;
    logic force_multiframe_count;
    logic [1:0] subclass;
    logic [1:0] alignment_release_delay;
    logic sw_sync_request;
    logic ilas_disable;
    logic lane_align;
    logic frame_align;
    logic scrambler_enable;
  } jtl_ctrl_s;

  typedef struct packed {
    logic [5:0] multiframe_count_init;
    logic [4:0] frame_octets_m1;
    logic [5:0] mf_octets_m1;
  } jtl_cfg_s;

  localparam jtl_ctrl_s CTRL_RESET = 17'h00000;
  localparam jtl_cfg_s CFG_RESET = 17'h00151;

  // ----------------------------------------------------------------
  // Counts and characters
  // ----------------------------------------------------------------
  localparam logic [2:0] SYNC_MIN_CYCLES = 3'h4;
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  localparam logic [1:0] SUBCLASS_1 = 2'h1;
  localparam logic [1:0] SUBCLASS_2 = 2'h2;
  localparam logic [2:0] TM_NONE = 3'h0;
  localparam logic [2:0] TM_D215 = 3'h1;
  localparam logic [2:0] TM_K285 = 3'h2;
  localparam logic [2:0] TM_RPAT = 3'h3;
  localparam logic [3:0] RPAT_LAST = 4'hb;
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_4 = 8'h9c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [7:0] D28_3 = 8'h7c;
  localparam logic [7:0] D28_7 = 8'hfc;
  localparam logic [7:0] D21_5 = 8'hb5;
  localparam logic [7:0] TP_CONST_OCTET = 8'h00;
  localparam logic [14:0] SCR_SEED = 15'h7fff;
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [3:0] ALT7_4B = 4'h7;

  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] ENC4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [7:0] RPAT [12] = '{
    8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
    8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};

endpackage

// ### jtl_link.sv
// Transmit data link layer: sync, alignment, replacement and 8b/10b.

// Operation
// RQ1: Every octet is 8b/10b encoded; frame contents go out MSB first.
// RQ2: Sync request low for four or more clocks starts K28.5 synchronisation.
// RQ3: Software sync request holds the link sending K28.5 continuously.
// RQ4: Alignment sequence follows synchronisation unless disabled by a control bit.
// RQ5: Leave synchronisation on first multiframe boundary, or later by release delay.
// RQ6: Unscrambled lane alignment: repeated multiframe last octet becomes K28.3.
// RQ7: Unscrambled frame alignment: repeated frame last octet becomes K28.7, unless just aligned.
// RQ8: Scrambled lane alignment: last multiframe octet equal D28.3 becomes K28.3.
// RQ9: Scrambled frame alignment: last frame octet equal D28.7 becomes K28.7.
// RQ10: No alignment enables means no replacement; both enables apply both.
// RQ11: Link test modes send fixed characters, never scrambled, including 120-bit random pattern.
// RQ12: Constant transport pattern with scrambler on yields a pseudo-random sequence.
// RQ13: Multiframe phase set by SYSREF in subclass 1, sync rise in 2.
// RQ14: SYSREF is active high, sampled on rising clock edges only.
// RQ15: Sync or reference event reloads multiframe counter to zero or forced value.
// RQ16: A periodic SYSREF period is a multiple of the multiframe period.
// RQ17: SYSREF stays low unless the link runs in subclass 1.
// RQ18: By default each relevant event resets dividers and, in subclasses 1/2, phase.
// RQ19: Events also reset test pattern phase, frame phase and odd/even selection; the code resets frame phase only together with multiframe phase.
// RQ20: First mask bit: later events reset phase only, not dividers or others.
// RQ21: Second mask bit: later events skip phase and dividers, still reset others.
// RQ22: Third mask bit: first event resets everything, later ones masked like second.
// RQ23: Systems with periodic SYSREF set one of the three mask bits.
// RQ24: Scrambler is bypassed during synchronisation and alignment sequence.
// RQ25: Keep sending K28.5 until sync deasserts, then advance at chosen boundary.
module jtl_link
  import jtl_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SYNC_REQUEST_N_I,
  input wire logic SYSREF_I,
  input wire logic [7:0] OCTET_I,
  output logic [9:0] LANE_O,
  output logic [1:0] LINK_STATE_O,
  output logic MF_BOUNDARY_O,
  output logic DIVIDER_RESET_O,
  output logic SYNC_RESET_O,
  output logic ODD_EVEN_SEL_O
);

  jtl_ctrl_s ctrl;
  jtl_cfg_s cfg;
  jtl_state_e state;
  logic sync_q;
  logic sysref_q;
  logic [2:0] low_cnt;
  logic [5:0] lmfc;
  logic [4:0] fo;
  logic [1:0] rel_left;
  logic [1:0] ila_mf;
  logic [3:0] rpat_idx;
  logic [14:0] scr_st;
  logic rd;
  logic mask3_used;
  logic [7:0] prev_frame_last;
  logic [7:0] prev_mf_last;
  logic prev_aligned;
  logic enter_cgs;
  logic sync_rise;
  logic sysref_rise;
  logic event_in;
  logic phase_ev;
  logic div_ev;
  logic other_ev;
  logic mf_end;
  logic frame_end;
  logic [7:0] next_d;
  logic next_k;
  logic next_repl;
  logic [7:0] src;
  logic [22:0] scr_res;
  logic [10:0] enc_res;
  logic [31:0] rd_mux;
  logic rd_err;

  // ----------------------------------------------------------------
  // Code functions
  // ----------------------------------------------------------------
  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k,
                                           input logic rd_in);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] x;
    logic [2:0] y;
    logic r6;
    logic alt;
    x = d[4:0];
    y = d[7:5];
    c6 = k ? K28_6B : ENC6[x];
    if (rd_in && ($countones(c6) != 3 || (!k && x == 5'd7))) begin
      c6 = ~c6;
    end
    r6 = rd_in ^ ($countones(c6) != 3);
    alt = (y == 3'd7) && (k || (!r6 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
          || (r6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    c4 = alt ? ALT7_4B : ENC4[y];
    if ((r6 && ($countones(c4) != 2 || y == 3'd3))
        || (k && !r6 && $countones(c4) == 2 && y != 3'd3)) begin
      c4 = ~c4;
    end
    return {r6 ^ ($countones(c4) != 2), c6, c4};
  endfunction

  // Self-synchronous scrambler, most significant bit first.
  function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] st);
    logic [14:0] s;
    logic [7:0] o;
    logic b;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ s[13] ^ s[14];
      o[i] = b;
      s = {s[13:0], b};
    end
    return {s, o};
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (PADDR_I == ADDR_CTRL) begin
      rd_mux = {15'h0000, ctrl};
    end else if (PADDR_I == ADDR_CFG) begin
      rd_mux = {10'h000, cfg.multiframe_count_init, 3'h0, cfg.frame_octets_m1,
                2'h0, cfg.mf_octets_m1};
    end else if (PADDR_I == ADDR_STAT) begin
      rd_mux = {15'h0000, (low_cnt == SYNC_MIN_CYCLES), 2'h0, lmfc, 2'h0, ila_mf,
                2'h0, state};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Zero wait states: ready rises for the access phase of every transfer.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & rd_err;
      PRDATA_O <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= CTRL_RESET;
      cfg <= CFG_RESET;
    end else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) begin
      if (PADDR_I == ADDR_CTRL) begin
        ctrl <= PWDATA_I[16:0];
      end else if (PADDR_I == ADDR_CFG) begin
        cfg <= {PWDATA_I[21:16], PWDATA_I[12:8], PWDATA_I[5:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync and reference events
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_q <= 1'b1;
      sysref_q <= 1'b0;
      low_cnt <= 3'h0;
    end else begin
      sync_q <= SYNC_REQUEST_N_I;
      sysref_q <= SYSREF_I; // RQ14
      if (SYNC_REQUEST_N_I) begin
        low_cnt <= 3'h0;
      end else if (low_cnt != SYNC_MIN_CYCLES) begin
        low_cnt <= low_cnt + 3'h1;
      end
    end
  end

  assign enter_cgs = !SYNC_REQUEST_N_I && low_cnt == SYNC_MIN_CYCLES - 3'h1; // RQ2
  assign sync_rise = SYNC_REQUEST_N_I & ~sync_q;
  assign sysref_rise = SYSREF_I & ~sysref_q; // RQ14
  assign event_in = (ctrl.subclass == SUBCLASS_1) ? sysref_rise : sync_rise; // RQ13 RQ18

  // Phase reset only exists in subclasses 1 and 2; masks gate each target.
  assign phase_ev = event_in && (ctrl.subclass == SUBCLASS_1 || ctrl.subclass == SUBCLASS_2)
                    && !ctrl.reset_mask_phase_dividers
                    && !(ctrl.reset_mask_after_first && mask3_used); // RQ18 RQ20 RQ21 RQ22
  assign div_ev = event_in && !ctrl.reset_mask_dividers && !ctrl.reset_mask_phase_dividers
                  && !(ctrl.reset_mask_after_first && mask3_used); // RQ20 RQ21 RQ22
  assign other_ev = event_in && !ctrl.reset_mask_dividers; // RQ19 RQ20 RQ21

  // The third mask lets exactly one event through after it is set.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask3_used <= 1'b0;
    end else if (!ctrl.reset_mask_after_first) begin
      mask3_used <= 1'b0;
    end else if (event_in) begin
      mask3_used <= 1'b1; // RQ22
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      DIVIDER_RESET_O <= 1'b0;
      SYNC_RESET_O <= 1'b0;
      ODD_EVEN_SEL_O <= 1'b0;
    end else begin
      DIVIDER_RESET_O <= div_ev; // RQ18
      SYNC_RESET_O <= other_ev; // RQ19
      ODD_EVEN_SEL_O <= other_ev ? 1'b0 : ~ODD_EVEN_SEL_O; // RQ19
    end
  end

  // ----------------------------------------------------------------
  // Multiframe and frame counters
  // ----------------------------------------------------------------
  assign mf_end = lmfc == cfg.mf_octets_m1;
  assign frame_end = fo == cfg.frame_octets_m1 || mf_end;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      lmfc <= 6'h00;
      fo <= 5'h00;
    end else if (phase_ev) begin
      lmfc <= ctrl.force_multiframe_count ? cfg.multiframe_count_init : 6'h00; // RQ15
      fo <= 5'h00; // RQ19
    end else begin
      lmfc <= mf_end ? 6'h00 : lmfc + 6'h01;
      fo <= frame_end ? 5'h00 : fo + 5'h01;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      MF_BOUNDARY_O <= 1'b0;
    end else begin
      MF_BOUNDARY_O <= mf_end && ctrl.subclass != 2'h0 && ctrl.subclass != 2'h3; // RQ13
    end
  end

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_CGS;
      rel_left <= 2'h0;
      ila_mf <= 2'h0;
    end else begin
      case (state)
        ST_CGS: begin
          if (!SYNC_REQUEST_N_I || ctrl.sw_sync_request) begin
            rel_left <= ctrl.alignment_release_delay; // RQ3 RQ25
          end else if (mf_end) begin
            if (rel_left == 2'h0) begin
              state <= ctrl.ilas_disable ? ST_DATA : ST_ILA; // RQ4 RQ5
              ila_mf <= 2'h0;
            end else begin
              rel_left <= rel_left - 2'h1; // RQ5
            end
          end
        end
        ST_ILA: begin
          if (enter_cgs || ctrl.sw_sync_request) begin
            state <= ST_CGS; // RQ2 RQ3
          end else if (mf_end) begin
            if (ila_mf == ILA_LAST_MF) begin
              state <= ST_DATA; // RQ4
            end else begin
              ila_mf <= ila_mf + 2'h1;
            end
          end
        end
        default: begin
          if (enter_cgs || ctrl.sw_sync_request) begin
            state <= ST_CGS; // RQ2 RQ3
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Character selection
  // ----------------------------------------------------------------
  assign src = ctrl.tp_constant ? TP_CONST_OCTET : OCTET_I; // RQ12
  assign scr_res = scramble(src, scr_st);

  always_comb begin
    next_d = src;
    next_k = 1'b0;
    next_repl = 1'b0;
    if (ctrl.link_test_select != TM_NONE) begin
      if (ctrl.link_test_select == TM_K285) begin
        next_d = K28_5; // RQ11
        next_k = 1'b1;
      end else if (ctrl.link_test_select == TM_RPAT) begin
        next_d = RPAT[rpat_idx]; // RQ11
      end else begin
        next_d = D21_5; // RQ11
      end
    end else begin
      case (state)
        ST_CGS: begin
          next_d = K28_5; // RQ2 RQ25
          next_k = 1'b1;
        end
        ST_ILA: begin
          next_k = 1'b1;
          if (lmfc == 6'h00) begin
            next_d = K28_0;
          end else if (ila_mf == 2'h1 && lmfc == 6'h01) begin
            next_d = K28_4;
          end else if (mf_end) begin
            next_d = K28_3;
          end else begin
            next_d = {2'h0, lmfc}; // RQ24
            next_k = 1'b0;
          end
        end
        default: begin
          if (ctrl.scrambler_enable) begin
            next_d = scr_res[7:0]; // RQ10 RQ12
            if (ctrl.lane_align && mf_end && next_d == D28_3) begin
              next_repl = 1'b1; // RQ8
            end else if (ctrl.frame_align && frame_end && next_d == D28_7) begin
              next_repl = 1'b1; // RQ9
            end
          end else begin
            if (ctrl.lane_align && mf_end && src == prev_mf_last) begin
              next_d = K28_3; // RQ6
              next_repl = 1'b1;
            end else if (ctrl.frame_align && frame_end && src == prev_frame_last
                         && !prev_aligned) begin
              next_d = K28_7; // RQ7
              next_repl = 1'b1;
            end
          end
          next_k = next_repl; // RQ10
        end
      endcase
    end
  end

  // Scrambler advances only on data octets, never on test or sequence octets.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      scr_st <= SCR_SEED;
    end else if (state == ST_DATA && ctrl.scrambler_enable
                 && ctrl.link_test_select == TM_NONE) begin
      scr_st <= scr_res[22:8]; // RQ24 RQ11
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      prev_frame_last <= 8'h00;
      prev_mf_last <= 8'h00;
      prev_aligned <= 1'b0;
    end else if (state == ST_DATA && frame_end) begin
      prev_frame_last <= src; // RQ7
      prev_aligned <= next_repl; // RQ7
      if (mf_end) begin
        prev_mf_last <= src; // RQ6
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rpat_idx <= 4'h0;
    end else if (other_ev || ctrl.link_test_select != TM_RPAT || rpat_idx == RPAT_LAST) begin
      rpat_idx <= 4'h0; // RQ19
    end else begin
      rpat_idx <= rpat_idx + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Encoder and outputs
  // ----------------------------------------------------------------
  assign enc_res = enc8b10b(next_d, next_k, rd); // RQ1

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd <= 1'b0;
      LANE_O <= 10'h000;
      LINK_STATE_O <= 2'h0;
    end else begin
      rd <= enc_res[10];
      LANE_O <= enc_res[9:0]; // RQ1
      LINK_STATE_O <= state;
    end
  end

endmodule

// ### jtl_rx_model.sv
// Behavioural receiver and reference source driving sync request and SYSREF.
module jtl_rx_model (
  input wire logic clk_i,
  output logic sync_n_o,
  output logic sysref_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sync_n_o = 1'b1;
    sysref_o = 1'b0;
  end

  // Holds the sync request low for the given number of clocks.
  task automatic sync_low(input int n);
    @(posedge clk_i);
    sync_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    sync_n_o <= 1'b1;
  endtask

  // Issues a one-shot reference pulse; the bench calls it only in subclass 1.
  task automatic sysref_pulse();
    @(posedge clk_i);
    sysref_o <= 1'b1;
    @(posedge clk_i);
    sysref_o <= 1'b0;
  endtask
endmodule

// ### jtl_link_sva.sv
// Port assertions for the transmit link layer.
module jtl_link_sva
  import jtl_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic SYNC_REQUEST_N_I,
  input wire logic SYSREF_I,
  input wire logic [9:0] LANE_O,
  input wire logic [1:0] LINK_STATE_O,
  input wire logic DIVIDER_RESET_O,
  input wire logic SYNC_RESET_O,
  input wire logic ODD_EVEN_SEL_O
);
  logic sr_q;
  logic sy_q;
  logic ev;
  // Remembers the last sampled levels so that rising edges can be seen.
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      sr_q <= 1'b0;
      sy_q <= 1'b1;
    end else begin
      sr_q <= SYSREF_I;
      sy_q <= SYNC_REQUEST_N_I;
    end
  end
  assign ev = (SYSREF_I && !sr_q) || (SYNC_REQUEST_N_I && !sy_q);

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  sequence s_low4;
    !SYNC_REQUEST_N_I [*4];
  endsequence
  sequence s_after_event;
    $past(ev) || $past(ev, 2);
  endsequence

  property p_enter_cgs;
    s_low4 |-> ##[1:2] LINK_STATE_O == ST_CGS;
  endproperty
  a_enter_cgs: assert property (p_enter_cgs) else $error("sync state not entered");
  property p_short;
    SYNC_REQUEST_N_I && $past(SYNC_REQUEST_N_I) && LINK_STATE_O == ST_DATA
      |=> LINK_STATE_O != ST_CGS;
  endproperty
  a_short: assert property (p_short) else $error("sync state without request");
  property p_cgs_char;
    !$past(RST_I) && LINK_STATE_O == ST_CGS && $past(LINK_STATE_O) == ST_CGS
      |-> LANE_O == 10'h0fa || LANE_O == 10'h305;
  endproperty
  a_cgs_char: assert property (p_cgs_char) else $error("comma missing");
  property p_ila_first;
    LINK_STATE_O == ST_ILA && $past(LINK_STATE_O) == ST_CGS
      |-> ##[0:2] (LANE_O == 10'h0f4 || LANE_O == 10'h30b);
  endproperty
  a_ila_first: assert property (p_ila_first) else $error("alignment start missing");
  property p_ila_order;
    $changed(LINK_STATE_O) && LINK_STATE_O == ST_ILA |-> $past(LINK_STATE_O) == ST_CGS;
  endproperty
  a_ila_order: assert property (p_ila_order) else $error("alignment out of order");
  property p_div;
    DIVIDER_RESET_O |-> s_after_event ##1 !DIVIDER_RESET_O;
  endproperty
  a_div: assert property (p_div) else $error("divider reset without event");
  property p_srst;
    SYNC_RESET_O |-> s_after_event ##1 !SYNC_RESET_O;
  endproperty
  a_srst: assert property (p_srst) else $error("sync reset without event");
  property p_odd;
    !SYNC_RESET_O && !$past(SYNC_RESET_O) && !$past(SYNC_RESET_O, 2) && !$past(RST_I)
      |-> ODD_EVEN_SEL_O != $past(ODD_EVEN_SEL_O);
  endproperty
  a_odd: assert property (p_odd) else $error("odd even select stuck");
endmodule

bind jtl_link jtl_link_sva sva_u (.MCLK_I(MCLK_I), .RST_I(RST_I),
  .SYNC_REQUEST_N_I(SYNC_REQUEST_N_I), .SYSREF_I(SYSREF_I), .LANE_O(LANE_O),
  .LINK_STATE_O(LINK_STATE_O), .DIVIDER_RESET_O(DIVIDER_RESET_O),
  .SYNC_RESET_O(SYNC_RESET_O), .ODD_EVEN_SEL_O(ODD_EVEN_SEL_O));

// ### jtl_link_test.sv
// Self-checking bench for the transmit link layer.
module jtl_link_test import jtl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, e, seen_ila;
  logic sync_n, sysref, mfb, divr, srst, oddev;
  logic [7:0] paddr, octet;
  logic [31:0] pwdata, prdata, r, s0, s;
  logic [9:0] lane;
  logic [1:0] state;
  int fail_count, n_tests, cyc, t, n;
  // Control word, code pair and count over four multiframes for each mode.
  logic [31:0] tc [10] = '{32'h0, 32'h4, 32'h2, 32'h6, 32'h6, 32'h1, 32'h2001, 32'h4001,
    32'h6001, 32'h10000};
  logic [9:0] ta [10] = '{10'h0f3, 10'h0f3, 10'h0f8, 10'h0f3, 10'h0f8, 10'h0f3, 10'h2aa,
    10'h0fa, 10'h2aa, 10'h274};
  logic [9:0] tb2 [10] = '{10'h30c, 10'h30c, 10'h307, 10'h30c, 10'h307, 10'h30c, 10'h2aa,
    10'h305, 10'h2aa, 10'h18b};
  int tn [10] = '{0, 4, 6, 4, 4, 0, 72, 72, 0, 72};

  jtl_link dut_u (.MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SYNC_REQUEST_N_I(sync_n),
    .SYSREF_I(sysref), .OCTET_I(octet), .LANE_O(lane), .LINK_STATE_O(state),
    .MF_BOUNDARY_O(mfb), .DIVIDER_RESET_O(divr), .SYNC_RESET_O(srst),
    .ODD_EVEN_SEL_O(oddev));
  jtl_rx_model rx_u (.clk_i(mclk), .sync_n_o(sync_n), .sysref_o(sysref));

  always #4 mclk = ~mclk;

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cnt(input logic [9:0] a, input logic [9:0] b, output int m);
    m = 0;
    repeat (72) begin
      @(posedge mclk);
      m += int'(lane === a || lane === b);
    end
  endtask

  task automatic wait_st(input logic [1:0] st, output int w);
    w = 0;
    seen_ila = 1'b0;
    while (state !== st && w < 400) begin
      @(posedge mclk);
      w++;
      if (state === ST_ILA) seen_ila = 1'b1;
    end
    check(32'(w < 400), 32'h1);
  endtask

  // Fires one reference pulse and packs pulse counts and boundary offset.
  task automatic ev(output logic [31:0] res);
    int nd;
    int ns;
    int off;
    nd = 0;
    ns = 0;
    off = 255;
    rx_u.sysref_pulse();
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk);
      nd += int'(divr === 1'b1);
      ns += int'(srst === 1'b1);
      if (mfb === 1'b1 && off == 255) off = k;
    end
    res = {8'(nd), 8'(ns), 16'(off)};
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    octet = 8'h5a;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0, r, e);
    check(r, 32'h0);
    apb(1'b0, ADDR_CFG, 32'h0, r, e);
    check(r, 32'h0000_0511);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    wait_st(ST_DATA, t);
    check({31'h0, seen_ila}, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0, r, e);
    check({30'h0, r[1:0]}, {30'h0, ST_DATA});
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, ADDR_CTRL, tc[i], r, e);
      repeat (20) @(posedge mclk);
      cnt(ta[i], tb2[i], n);
      check(32'(n), 32'(tn[i]));
    end
    // A scrambled constant pattern must rarely show the plain zero octet.
    apb(1'b1, ADDR_CTRL, 32'h10001, r, e);
    repeat (20) @(posedge mclk);
    cnt(10'h274, 10'h18b, n);
    check(32'(n < 8), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0, r, e);
    rx_u.sync_low(3);
    repeat (4) @(posedge mclk);
    check({30'h0, state}, {30'h0, ST_DATA});
    fork
      rx_u.sync_low(6);
      apb(1'b1, ADDR_CTRL, 32'h10, r, e);
    join
    n = 0;
    repeat (100) begin
      @(posedge mclk);
      n += int'(state !== ST_CGS);
    end
    check(32'(n), 32'h0);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, ADDR_CTRL, 32'h8 | 32'(d << 5), r, e);
      wait_st(ST_DATA, t);
      rx_u.sync_low(6);
      wait_st(ST_DATA, t);
      check({31'h0, seen_ila}, 32'h0);
      check(32'(t >= 18 * d && t <= 18 * d + 24), 32'h1);
    end
    apb(1'b1, ADDR_CTRL, 32'h80, r, e);
    ev(s0);
    check({16'h0, s0[31:16]}, 32'h0101);
    repeat (7) @(posedge mclk);
    ev(s);
    check(s, s0);
    apb(1'b1, ADDR_CFG, 32'h0005_0511, r, e);
    apb(1'b1, ADDR_CTRL, 32'h280, r, e);
    ev(s);
    check(s, s0 - 32'h5);
    apb(1'b1, ADDR_CTRL, 32'h480, r, e);
    ev(s);
    check(s, {16'h0, s0[15:0]});
    apb(1'b1, ADDR_CTRL, 32'h880, r, e);
    ev(s);
    check({16'h0, s[31:16]}, 32'h0001);
    apb(1'b1, ADDR_CTRL, 32'h1080, r, e);
    ev(s);
    check({16'h0, s[31:16]}, 32'h0101);
    ev(s);
    check({16'h0, s[31:16]}, 32'h0001);
    apb(1'b1, ADDR_CTRL, 32'h0, r, e);
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      n += int'(mfb !== 1'b0);
    end
    check(32'(n), 32'h0);
    give_verdict();
  end
endmodule
